/* common/apd_pkg.sv */
package apd_pkg;
	// Idle periods of the power-down clock before power-down is raised.
	localparam logic [3:0] APD_IDLE_LIMIT = 4'hF;
	// Field positions in the first power-mode register.
	localparam int PMR0_APD_EN_BIT = 1;
	localparam int PMR0_TURBO_OFF_BIT = 3;
	localparam int PMR0_ARRAY_CLK_OFF_BIT = 4;
	localparam int PMR0_MCELL_CLK_OFF_BIT = 5;
	// Field positions in the third power-mode register.
	localparam int PMR2_CNTL0_OFF_BIT = 2;
	localparam int PMR2_CNTL1_OFF_BIT = 3;
	localparam int PMR2_CNTL2_OFF_BIT = 4;
	localparam int PMR2_STROBE_OFF_BIT = 5;
	localparam int PMR2_DBE_OFF_BIT = 6;
	// Power-up value of both power-mode registers.
	localparam logic [7:0] PMR_RESET_VALUE = 8'h00;
	// Writable bits of each register; unused bits read as zero.
	localparam logic [7:0] PMR0_WR_MASK = 8'h3A;
	localparam logic [7:0] PMR2_WR_MASK = 8'h7C;
	// Reset value of a synchroniser stage.
	localparam logic [1:0] SYNC_RESET_VALUE = 2'h0;
	localparam logic [3:0] CNT_RESET_VALUE = 4'h0;
endpackage

/* rtl/apd_edge.sv */
`timescale 1ns/10ps
// Detects any change of a synchronised level, one-cycle pulse.
module apd_edge (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_level,
	output logic o_edge,
	output logic o_rise
);
	logic last_reg;
	logic last_next;

	// Remember last level.
	always_comb begin
		last_next = i_level;
	end

	// Register the previous level.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			last_reg <= 1'b0;
		end else begin
			last_reg <= last_next;
		end
	end

	assign o_edge = i_level ^ last_reg;
	assign o_rise = i_level & ~last_reg;
endmodule

/* rtl/apd_sync.sv */
`timescale 1ns/10ps
// Two-flop synchroniser for one asynchronous level.
module apd_sync (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_async,
	output logic o_sync
);
	logic [1:0] stage_reg;
	logic [1:0] stage_next;

	// Shift the pin level through two stages.
	always_comb begin
		stage_next = {stage_reg[0], i_async};
	end

	// Register the stages; only the second stage is read outside.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stage_reg <= apd_pkg::SYNC_RESET_VALUE;
		end else begin
			stage_reg <= stage_next;
		end
	end

	assign o_sync = stage_reg[1];
endmodule

/* rtl/apd_unit.sv */
`timescale 1ns/10ps
// Operation
// - Enabled unit counts idle periods, four-bit counter.
// - Fifteen idle periods raise power-down flag.
// - Enable permits entering power-down only while select is high and reset is low.
// - Strobe pulsing again ends power-down.
// - Select low or reset high ends power-down.
// - Power-down blocks bus from memories, logic.
// - Power-down deselects all memories into standby.
// - Logic arrays stay active; data and peripheral port drivers turn off.
// - Port pins hold, undefined, or tri-state.
// - Clock blocking never stops the idle counter.
// - Power-down clock feeds macrocells and counter.
// - Blocking bits stop signals reaching logic arrays.
// - Turbo bit set turns turbo off.
// - Select high disables flash, static memory, decode.
// - Select deselect never blocks signals or logic.
// - Memories wake on input change, then standby.
// - Changing unblocked inputs keep logic awake.
// - Count only when enabled and strobe idle-level.
// - Power-down enable is bit one, register zero.
// - Turbo control is bit three, register zero.
// - Power-mode registers clear only at power-up.
module apd_unit (
	input wire logic I_MCLK,
	input wire logic I_RST_N,
	input wire logic i_POWER_UP,
	input wire logic i_DEVICE_RESET,
	input wire logic i_STROBE_PIN,
	input wire logic i_CLOCK_PIN,
	input wire logic i_SELECT_PIN,
	input wire logic i_STROBE_IDLE_POL,
	input wire logic i_PMR0_WE,
	input wire logic i_PMR2_WE,
	input wire logic [7:0] i_PMR_WDATA,
	input wire logic [3:0] i_CNTL_IN,
	input wire logic i_DBE_IN,
	input wire logic [7:0] i_BUS_ADDR,
	input wire logic [7:0] i_BUS_DATA,
	output logic [7:0] o_PMR0,
	output logic [7:0] o_PMR2,
	output logic o_POWER_DOWN_FLAG,
	output logic [3:0] o_IDLE_COUNT,
	output logic [7:0] o_MEM_ADDR,
	output logic [7:0] o_MEM_DATA,
	output logic o_FLASH_SEL_EN,
	output logic o_SRAM_SEL_EN,
	output logic o_IO_REG_SEL_EN,
	output logic o_MEM_WAKE,
	output logic [7:0] o_LOGIC_ADDR,
	output logic [7:0] o_LOGIC_DATA,
	output logic [2:0] o_LOGIC_CNTL,
	output logic o_LOGIC_STROBE,
	output logic o_LOGIC_DBE,
	output logic o_ARRAY_CLK,
	output logic o_MCELL_CLK,
	output logic o_TURBO_ON,
	output logic o_LOGIC_ACTIVE,
	output logic o_HOLD_IO_PINS,
	output logic o_ADDR_OUT_UNDEF,
	output logic o_DATA_PORT_OE,
	output logic o_PERIPH_OE
);
	logic strobe_s;
	logic clock_s;
	logic select_s;
	logic strobe_edge;
	logic clock_rise;
	logic clock_edge;
	logic dev_rst_s;

	// Bring the four pins into the clock domain before any logic reads them.
	apd_sync u_sync_strobe (
		.i_clk(I_MCLK),
		.i_rst_n(I_RST_N),
		.i_async(i_STROBE_PIN),
		.o_sync(strobe_s)
	);
	apd_sync u_sync_clock (
		.i_clk(I_MCLK),
		.i_rst_n(I_RST_N),
		.i_async(i_CLOCK_PIN),
		.o_sync(clock_s)
	);
	apd_sync u_sync_select (
		.i_clk(I_MCLK),
		.i_rst_n(I_RST_N),
		.i_async(i_SELECT_PIN),
		.o_sync(select_s)
	);
	apd_sync u_sync_reset (
		.i_clk(I_MCLK),
		.i_rst_n(I_RST_N),
		.i_async(i_DEVICE_RESET),
		.o_sync(dev_rst_s)
	);

	// Strobe activity and power-down clock periods as pulses.
	apd_edge u_edge_strobe (
		.i_clk(I_MCLK),
		.i_rst_n(I_RST_N),
		.i_level(strobe_s),
		.o_edge(strobe_edge),
		.o_rise()
	);
	apd_edge u_edge_clock (
		.i_clk(I_MCLK),
		.i_rst_n(I_RST_N),
		.i_level(clock_s),
		.o_edge(clock_edge),
		.o_rise(clock_rise)
	);

	// Power-mode registers.
	logic [7:0] pmr0_reg;
	logic [7:0] pmr0_next;
	logic [7:0] pmr2_reg;
	logic [7:0] pmr2_next;

	// Writes land only in defined bits; device reset leaves them alone.
	always_comb begin
		pmr0_next = pmr0_reg;
		pmr2_next = pmr2_reg;
		if (i_PMR0_WE) begin
			pmr0_next = i_PMR_WDATA & apd_pkg::PMR0_WR_MASK;
		end
		if (i_PMR2_WE) begin
			pmr2_next = i_PMR_WDATA & apd_pkg::PMR2_WR_MASK;
		end
		// A power-up event outranks a write in the same cycle.
		if (i_POWER_UP) begin
			pmr0_next = apd_pkg::PMR_RESET_VALUE;
			pmr2_next = apd_pkg::PMR_RESET_VALUE;
		end
	end

	// Cleared only by the power-up reset.
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pmr0_reg <= apd_pkg::PMR_RESET_VALUE;
			pmr2_reg <= apd_pkg::PMR_RESET_VALUE;
		end else begin
			pmr0_reg <= pmr0_next;
			pmr2_reg <= pmr2_next;
		end
	end

	logic apd_en;
	logic strobe_idle;
	assign apd_en = pmr0_reg[apd_pkg::PMR0_APD_EN_BIT];
	assign strobe_idle = (strobe_s == i_STROBE_IDLE_POL) && !strobe_edge;

	// Idle counter and power-down state.
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic pwrdn_reg;
	logic pwrdn_next;

	// Count clock periods while idle; toggles clear; wake sources exit.
	always_comb begin
		cnt_next = cnt_reg;
		pwrdn_next = pwrdn_reg;
		if (!apd_en || !strobe_idle) begin
			cnt_next = apd_pkg::CNT_RESET_VALUE;
		end else if (clock_rise && cnt_reg != apd_pkg::APD_IDLE_LIMIT) begin
			cnt_next = cnt_reg + 4'h1;
		end
		if (apd_en && cnt_reg == apd_pkg::APD_IDLE_LIMIT) begin
			pwrdn_next = 1'b1;
		end
		if (strobe_edge || !select_s || dev_rst_s || !apd_en) begin
			pwrdn_next = 1'b0;
			if (strobe_edge) begin
				cnt_next = apd_pkg::CNT_RESET_VALUE;
			end
		end
	end

	// Register counter and flag.
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cnt_reg <= apd_pkg::CNT_RESET_VALUE;
			pwrdn_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			pwrdn_reg <= pwrdn_next;
		end
	end

	// Memory and logic-array side outputs, all registered.
	logic [7:0] maddr_reg;
	logic [7:0] mdata_reg;
	logic [7:0] laddr_reg;
	logic [7:0] ldata_reg;
	logic [2:0] lcntl_reg;
	logic lstb_reg;
	logic ldbe_reg;
	logic aclk_reg;
	logic mclk_reg;
	logic fsel_reg;
	logic ssel_reg;
	logic iosel_reg;
	logic wake_reg;
	logic lact_reg;
	logic [7:0] maddr_next;
	logic [7:0] mdata_next;
	logic [7:0] laddr_next;
	logic [7:0] ldata_next;
	logic [2:0] lcntl_next;
	logic lstb_next;
	logic ldbe_next;
	logic aclk_next;
	logic mclk_next;
	logic fsel_next;
	logic ssel_next;
	logic iosel_next;
	logic wake_next;
	logic lact_next;
	logic oe_reg;
	logic oe_next;
	logic turbo_reg;
	logic turbo_next;
	logic pd_now;
	assign pd_now = pwrdn_next;

	// Gate the bus and control inputs by power-down and blocking bits.
	always_comb begin
		maddr_next = maddr_reg;
		mdata_next = mdata_reg;
		laddr_next = laddr_reg;
		ldata_next = ldata_reg;
		if (!pd_now) begin
			maddr_next = i_BUS_ADDR;
			mdata_next = i_BUS_DATA;
			laddr_next = i_BUS_ADDR;
			ldata_next = i_BUS_DATA;
		end
		// Memories wake only when a passed input changes.
		wake_next = (maddr_next != maddr_reg) || (mdata_next != mdata_reg);
		lcntl_next[0] = i_CNTL_IN[0] & ~pmr2_reg[apd_pkg::PMR2_CNTL0_OFF_BIT];
		lcntl_next[1] = i_CNTL_IN[1] & ~pmr2_reg[apd_pkg::PMR2_CNTL1_OFF_BIT];
		lcntl_next[2] = i_CNTL_IN[2] & ~pmr2_reg[apd_pkg::PMR2_CNTL2_OFF_BIT];
		lstb_next = strobe_s & ~pmr2_reg[apd_pkg::PMR2_STROBE_OFF_BIT];
		ldbe_next = i_DBE_IN & ~pmr2_reg[apd_pkg::PMR2_DBE_OFF_BIT];
		aclk_next = clock_s & ~pmr0_reg[apd_pkg::PMR0_ARRAY_CLK_OFF_BIT];
		mclk_next = clock_s & ~pmr0_reg[apd_pkg::PMR0_MCELL_CLK_OFF_BIT];
		// Select and power-down deselect memories, not logic.
		fsel_next = select_s == 1'b0 && !pd_now;
		ssel_next = select_s == 1'b0 && !pd_now;
		iosel_next = select_s == 1'b0 && !pd_now;
		// Logic stays up with turbo or any changing unblocked input.
		lact_next = !pmr0_reg[apd_pkg::PMR0_TURBO_OFF_BIT]
			|| (lcntl_next != lcntl_reg)
			|| (lstb_next != lstb_reg) || (ldbe_next != ldbe_reg)
			|| (laddr_next != laddr_reg) || (ldata_next != ldata_reg)
			|| (aclk_next != aclk_reg && clock_edge);
		// Port drivers and turbo status leave the block from flip-flops.
		oe_next = !pd_now;
		turbo_next = !pmr0_next[apd_pkg::PMR0_TURBO_OFF_BIT];
	end

	// Register the gated signals.
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			maddr_reg <= 8'h00;
			mdata_reg <= 8'h00;
			laddr_reg <= 8'h00;
			ldata_reg <= 8'h00;
			lcntl_reg <= 3'h0;
			lstb_reg <= 1'b0;
			ldbe_reg <= 1'b0;
			aclk_reg <= 1'b0;
			mclk_reg <= 1'b0;
			fsel_reg <= 1'b0;
			ssel_reg <= 1'b0;
			iosel_reg <= 1'b0;
			wake_reg <= 1'b0;
			lact_reg <= 1'b1;
			oe_reg <= 1'b1;
			turbo_reg <= 1'b1;
		end else begin
			maddr_reg <= maddr_next;
			mdata_reg <= mdata_next;
			laddr_reg <= laddr_next;
			ldata_reg <= ldata_next;
			lcntl_reg <= lcntl_next;
			lstb_reg <= lstb_next;
			ldbe_reg <= ldbe_next;
			aclk_reg <= aclk_next;
			mclk_reg <= mclk_next;
			fsel_reg <= fsel_next;
			ssel_reg <= ssel_next;
			iosel_reg <= iosel_next;
			wake_reg <= wake_next;
			lact_reg <= lact_next;
			oe_reg <= oe_next;
			turbo_reg <= turbo_next;
		end
	end

	// Port pin behaviour follows the flag.
	assign o_HOLD_IO_PINS = pwrdn_reg;
	assign o_ADDR_OUT_UNDEF = pwrdn_reg;
	assign o_DATA_PORT_OE = oe_reg;
	assign o_PERIPH_OE = oe_reg;

	assign o_PMR0 = pmr0_reg;
	assign o_PMR2 = pmr2_reg;
	assign o_POWER_DOWN_FLAG = pwrdn_reg;
	assign o_IDLE_COUNT = cnt_reg;
	assign o_MEM_ADDR = maddr_reg;
	assign o_MEM_DATA = mdata_reg;
	assign o_FLASH_SEL_EN = fsel_reg;
	assign o_SRAM_SEL_EN = ssel_reg;
	assign o_IO_REG_SEL_EN = iosel_reg;
	assign o_MEM_WAKE = wake_reg;
	assign o_LOGIC_ADDR = laddr_reg;
	assign o_LOGIC_DATA = ldata_reg;
	assign o_LOGIC_CNTL = lcntl_reg;
	assign o_LOGIC_STROBE = lstb_reg;
	assign o_LOGIC_DBE = ldbe_reg;
	assign o_ARRAY_CLK = aclk_reg;
	assign o_MCELL_CLK = mclk_reg;
	assign o_TURBO_ON = turbo_reg;
	assign o_LOGIC_ACTIVE = lact_reg;
endmodule

/* testbench/apd_mcu_model.sv */
`timescale 1ns/10ps
// Microcontroller side: strobe pulses while running, bus always toggles.
module apd_mcu_model (
	input wire logic i_clk,
	input wire logic i_run,
	output logic o_strobe,
	output logic o_clk_pin,
	output logic [7:0] o_addr
);
	logic [2:0] cnt = 3'h0;
	initial o_strobe = 1'b1;
	initial o_addr = 8'h00;
	assign o_clk_pin = cnt[2];
	// Strobe rests high when the core sleeps; bus noise never stops.
	always @(negedge i_clk) begin
		cnt <= cnt + 3'h1;
		o_addr <= o_addr + 8'h01;
		if (!i_run)
			o_strobe <= 1'b1;
		else if (cnt[0])
			o_strobe <= !o_strobe;
	end
endmodule

/* testbench/apd_unit_bench.sv */
`timescale 1ns/10ps
// Drives the power-down unit through register writes and strobe activity.
module apd_unit_bench;
	logic clk = 1'b0, rst_n = 1'b0, pwr_up = 1'b0, dev_rst = 1'b0;
	logic sel_pin = 1'b1, run = 1'b1, we0 = 1'b0, we2 = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic strobe, clk_pin, flag, flash, oe, hold, dbe_o;
	logic sram, iosel, wake, lstb, aclk, mclk, turbo, lact, undef, poe;
	logic [3:0] cnt;
	logic [7:0] addr, pmr0, pmr2, maddr, mdata, laddr, ldata, saved;
	logic [2:0] cntl_o;
	int num_errors = 0, n_tests = 0, cycles = 0;
	apd_mcu_model mcu (.i_clk(clk), .i_run(run), .o_strobe(strobe),
		.o_clk_pin(clk_pin), .o_addr(addr));
	apd_unit dut (.I_MCLK(clk), .I_RST_N(rst_n), .i_POWER_UP(pwr_up),
		.i_DEVICE_RESET(dev_rst), .i_STROBE_PIN(strobe),
		.i_CLOCK_PIN(clk_pin), .i_SELECT_PIN(sel_pin),
		.i_STROBE_IDLE_POL(1'b1), .i_PMR0_WE(we0), .i_PMR2_WE(we2),
		.i_PMR_WDATA(wdata), .i_CNTL_IN(4'hF), .i_DBE_IN(1'b1),
		.i_BUS_ADDR(addr), .i_BUS_DATA(~addr), .o_PMR0(pmr0),
		.o_PMR2(pmr2), .o_POWER_DOWN_FLAG(flag), .o_IDLE_COUNT(cnt),
		.o_MEM_ADDR(maddr), .o_MEM_DATA(mdata), .o_FLASH_SEL_EN(flash),
		.o_SRAM_SEL_EN(sram), .o_IO_REG_SEL_EN(iosel), .o_MEM_WAKE(wake),
		.o_LOGIC_ADDR(laddr), .o_LOGIC_DATA(ldata), .o_LOGIC_CNTL(cntl_o),
		.o_LOGIC_STROBE(lstb), .o_LOGIC_DBE(dbe_o), .o_ARRAY_CLK(aclk),
		.o_MCELL_CLK(mclk), .o_TURBO_ON(turbo), .o_LOGIC_ACTIVE(lact),
		.o_HOLD_IO_PINS(hold), .o_ADDR_OUT_UNDEF(undef),
		.o_DATA_PORT_OE(oe), .o_PERIPH_OE(poe));
	always #5 clk = ~clk;
	// Prints the counts and the verdict, then ends the run.
	task give_verdict;
		$display("errors %0d comparisons %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Cuts a hung run short.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors = num_errors + 1;
			give_verdict();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One-cycle write strobe to register zero or register two.
	task automatic wr(input logic two, input logic [7:0] d);
		@(negedge clk);
		wdata = d;
		we0 = !two;
		we2 = two;
		@(negedge clk);
		we0 = 1'b0;
		we2 = 1'b0;
		@(negedge clk);
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Waits, under a bound, for the power-down flag.
	task automatic wait_pd;
		int i;
		for (i = 0; i < 400 && flag !== 1'b1; i++)
			@(negedge clk);
	endtask
	// Main sequence of scenarios.
	initial begin
		idle(20);
		rst_n = 1'b1;
		idle(2);
		chk(pmr0, 8'h00);
		chk({6'h00, turbo, oe}, 8'h03);
		wr(1'b0, 8'hFF);
		chk(pmr0, 8'h3A);
		chk({7'h00, turbo}, 8'h00);
		chk({6'h00, aclk, mclk}, 8'h00);
		wr(1'b1, 8'hFF);
		chk(pmr2, 8'h7C);
		chk({3'h0, lstb, dbe_o, cntl_o}, 8'h00);
		chk(maddr, addr);
		chk(mdata, ~addr);
		wr(1'b1, 8'h00);
		chk({4'h0, dbe_o, cntl_o}, 8'h0F);
		wr(1'b0, 8'h02);
		chk({6'h00, turbo, lact}, 8'h03);
		run = 1'b0;
		idle(80);
		chk(flag, 1'b0);
		wait_pd();
		chk({hold, oe, flag, flash}, 8'h0A);
		chk({undef, poe, sram, iosel}, 8'h08);
		chk({4'h0, cnt}, 8'h0F);
		chk({4'h0, dbe_o, cntl_o}, 8'h0F);
		chk({7'h00, wake}, 8'h00);
		saved = maddr;
		idle(5);
		chk(maddr, saved);
		chk(laddr, saved);
		chk(mdata, ~saved);
		chk(ldata, ~saved);
		run = 1'b1;
		idle(10);
		chk(flag, 1'b0);
		wr(1'b0, 8'h3A);
		run = 1'b0;
		wait_pd();
		chk(flag, 1'b1);
		chk({6'h00, aclk, lact}, 8'h00);
		dev_rst = 1'b1;
		idle(4);
		chk(flag, 1'b0);
		chk(pmr0, 8'h3A);
		dev_rst = 1'b0;
		sel_pin = 1'b0;
		idle(200);
		chk({4'h0, flag, flash, sram, iosel}, 8'h07);
		chk({7'h00, wake}, 8'h01);
		sel_pin = 1'b1;
		wr(1'b0, 8'h00);
		idle(200);
		chk({3'h0, flag, cnt}, 8'h00);
		wr(1'b0, 8'h3A);
		pwr_up = 1'b1;
		idle(1);
		pwr_up = 1'b0;
		idle(1);
		chk(pmr0, 8'h00);
		chk({6'h00, turbo, oe}, 8'h03);
		give_verdict();
	end
endmodule

/* testbench/apd_unit_monitor.sv */
`timescale 1ns/10ps
// Watches power-down entry, wake-up and gating at the unit's ports.
module apd_unit_monitor (
	input wire logic I_MCLK,
	input wire logic I_RST_N,
	input wire logic i_POWER_UP,
	input wire logic i_DEVICE_RESET,
	input wire logic i_SELECT_PIN,
	input wire logic i_PMR0_WE,
	input wire logic [7:0] i_PMR_WDATA,
	input wire logic [7:0] o_PMR0,
	input wire logic o_POWER_DOWN_FLAG,
	input wire logic [3:0] o_IDLE_COUNT,
	input wire logic [7:0] o_MEM_ADDR,
	input wire logic o_FLASH_SEL_EN,
	input wire logic o_TURBO_ON,
	input wire logic o_HOLD_IO_PINS,
	input wire logic o_DATA_PORT_OE
);
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_N);
	// A wake source held long enough to pass the synchronisers.
	sequence wake_held;
		(i_DEVICE_RESET || !i_SELECT_PIN) [*4];
	endsequence
	// A quiet register-zero cycle with no write to it and no power-up event.
	sequence no_write;
		!i_PMR0_WE && !i_POWER_UP;
	endsequence
	flag_rise_a: assert property ($rose(o_POWER_DOWN_FLAG) |->
		$past(o_IDLE_COUNT) == 4'hF) else $error("flag rose early");
	count_step_a: assert property ($changed(o_IDLE_COUNT) &&
		o_IDLE_COUNT != 4'h0 |-> o_IDLE_COUNT == $past(o_IDLE_COUNT) + 1)
		else $error("idle count jumped");
	turbo_map_a: assert property (o_TURBO_ON == !o_PMR0[3])
		else $error("turbo output wrong");
	pmr0_write_a: assert property (i_PMR0_WE && !i_POWER_UP |=>
		o_PMR0 == ($past(i_PMR_WDATA) & 8'h3A)) else $error("bad write");
	pmr_hold_a: assert property (no_write |=> $stable(o_PMR0))
		else $error("register changed without write");
	pd_desel_a: assert property (o_POWER_DOWN_FLAG |->
		!o_FLASH_SEL_EN) else $error("memory selected in power-down");
	sel_high_a: assert property (i_SELECT_PIN [*4] |->
		!o_FLASH_SEL_EN) else $error("memory selected with select high");
	pins_pd_a: assert property (o_HOLD_IO_PINS == o_POWER_DOWN_FLAG &&
		o_DATA_PORT_OE == !o_POWER_DOWN_FLAG) else $error("pin modes wrong");
	bus_freeze_a: assert property (o_POWER_DOWN_FLAG &&
		$past(o_POWER_DOWN_FLAG) |-> $stable(o_MEM_ADDR))
		else $error("memory bus moved in power-down");
	wake_src_a: assert property (wake_held |-> !o_POWER_DOWN_FLAG)
		else $error("no wake from select or reset");
endmodule

bind apd_unit apd_unit_monitor mon (.I_MCLK, .I_RST_N, .i_POWER_UP,
	.i_DEVICE_RESET, .i_SELECT_PIN, .i_PMR0_WE, .i_PMR_WDATA, .o_PMR0,
	.o_POWER_DOWN_FLAG, .o_IDLE_COUNT, .o_MEM_ADDR, .o_FLASH_SEL_EN,
	.o_TURBO_ON, .o_HOLD_IO_PINS, .o_DATA_PORT_OE);
